// ---- rtl/pmc_defs.svh ----
// Function
// RULE1: timer select code picks stabilisation wait count
// RULE2: medium clock divides oscillator by 16 to 128
// RULE3: low-speed flag picks system or watch subclock
// RULE4: standby clear: sleep enters sleep or subsleep
// RULE5: standby set: sleep enters standby or watch
// RULE6: from active, timer A bit picks watch
// RULE7: subactive clock is watch clock /8, /4, /2
// RULE8: medium flag picks high or medium speed
// RULE9: direct flag clear: only low-power entries
// RULE10: direct from high to medium or subactive
// RULE11: direct from medium to high or subactive
// RULE12: direct from subactive to high or medium
// RULE13: noise sampling is oscillator /16 or /4
// RULE14: edge bit picks falling or rising edges
// RULE15: hold CPU for wait after standby, watch
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// register offsets
`define PMC_OFS_POWER_MODE 8'h00
`define PMC_OFS_CLK_TRANS 8'h01
`define PMC_OFS_EDGE_SEL 8'h02
`define PMC_OFS_MODE_STATUS 8'h03

// power_mode_control fields
`define PMC_PM_STBY_BIT 7
`define PMC_PM_STS_HI 6
`define PMC_PM_STS_LO 4
`define PMC_PM_LOW_SPEED_BIT 3
`define PMC_PM_MA_HI 1
`define PMC_PM_MA_LO 0
`define PMC_PM_RESET 8'h07
`define PMC_PM_FIXED_MASK 8'h04

// clock_transition_control fields
`define PMC_CT_NOISE_BIT 4
`define PMC_CT_DIRECT_BIT 3
`define PMC_CT_MED_BIT 2
`define PMC_CT_SA_HI 1
`define PMC_CT_SA_LO 0
`define PMC_CT_RESET 8'hf0
`define PMC_CT_FIXED_MASK 8'he0

// edge select and status fields
`define PMC_ES_INT3_BIT 0
`define PMC_ES_RESET 8'h00
`define PMC_ES_WRITE_MASK 8'h01
`define PMC_ST_MODE_HI 2
`define PMC_ST_MODE_LO 0
`define PMC_ST_HOLD_BIT 3
`define PMC_ST_OSC_BIT 4

// stabilisation wait in states, codes 2 to 7
`define PMC_WAIT_CODE2 15'd1024
`define PMC_WAIT_CODE3 15'd2048
`define PMC_WAIT_CODE4 15'd4096
`define PMC_WAIT_CODE5 15'd2
`define PMC_WAIT_CODE6 15'd8
`define PMC_WAIT_CODE7 15'd16

// divide ratios
`define PMC_MED_DIV0 8'd16
`define PMC_MED_DIV1 8'd32
`define PMC_MED_DIV2 8'd64
`define PMC_MED_DIV3 8'd128
`define PMC_SUB_DIV0 8'd8
`define PMC_SUB_DIV1 8'd4
`define PMC_SUB_DIV2 8'd2
`define PMC_NOISE_DIV0 8'd16
`define PMC_NOISE_DIV1 8'd4

`endif

// ---- rtl/pmc_pkg.sv ----
package pmc_pkg;
	typedef enum logic [2:0] {
		PMC_ACT_HIGH,
		PMC_ACT_MED,
		PMC_SUBACTIVE,
		PMC_SLEEP,
		PMC_SUBSLEEP,
		PMC_STANDBY,
		PMC_WATCH,
		PMC_OSC_WAIT
	} pmc_mode_e;
	typedef logic [7:0] pmc_byte_t;
endpackage

// ---- rtl/pmc_divider.sv ----
`timescale 1ns/1ps
// divides a stream of enable pulses by a run-time ratio
module pmc_divider #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_tick,
	input wire logic [WIDTH-1:0] ratio,
	output logic out_tick
);
	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] last;

	if (WIDTH < 2) begin : g_bad_width
		$error("pmc_divider: WIDTH too small");
	end

	assign last = (ratio == '0) ? '0 : ratio - 1'b1;

	// >= so a ratio shrunk mid-count cannot strand the counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
		end else if (in_tick) begin
			if (cnt_reg >= last)
				cnt_reg <= '0;
			else
				cnt_reg <= cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			out_tick <= 1'b0;
		else
			out_tick <= in_tick && (cnt_reg >= last);
	end
endmodule // pmc_divider

// ---- rtl/pmc_wait_timer.sv ----
`timescale 1ns/1ps
// counts a loaded number of clock cycles, then pulses done
module pmc_wait_timer #(
	parameter int WIDTH = 15
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] cnt_reg;

	if (WIDTH < 2) begin : g_bad_width
		$error("pmc_wait_timer: WIDTH too small");
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			busy <= 1'b0;
		end else if (load) begin
			cnt_reg <= (count == '0) ? WIDTH'(1) : count;
			busy <= 1'b1;
		end else if (busy) begin
			cnt_reg <= cnt_reg - 1'b1;
			if (cnt_reg == WIDTH'(1))
				busy <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			done <= 1'b0;
		else
			done <= busy && !load && (cnt_reg == WIDTH'(1));
	end
endmodule // pmc_wait_timer

// ---- rtl/pmc_power_mode_controller.sv ----
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_power_mode_controller import pmc_pkg::*; #(
	parameter int WAIT_W = 15,
	parameter int WAIT_CODE0_STATES = 8192,
	parameter int WAIT_CODE1_STATES = 16384
) (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire logic SLEEP_EXEC,
	input wire logic WAKE_EVENT,
	input wire logic TIMER_A_CLK_BIT,
	input wire logic WATCH_CLK_PIN,
	input wire logic EXT_INT3_PIN,
	input wire logic TIMER_F_PIN,
	output logic [2:0] POWER_MODE,
	output logic CPU_CLK_EN,
	output logic CPU_CLK_FROM_SUB,
	output logic CPU_HOLD,
	output logic OSC_ENABLE,
	output logic NOISE_SAMPLE_EN,
	output logic DIRECT_TRANSITION,
	output logic EXT_INT3_EDGE,
	output logic TIMER_F_EDGE
);
	localparam int WAIT_MAX = (1 << WAIT_W) - 1;

	if (WAIT_W < 15 || WAIT_W > 24) begin : g_bad_wait_w
		$error("pmc: WAIT_W must hold the longest wait");
	end
	if (WAIT_CODE0_STATES < 1 || WAIT_CODE0_STATES > WAIT_MAX) begin : g_bad_c0
		$error("pmc: WAIT_CODE0_STATES out of range");
	end
	if (WAIT_CODE1_STATES < 1 || WAIT_CODE1_STATES > WAIT_MAX) begin : g_bad_c1
		$error("pmc: WAIT_CODE1_STATES out of range");
	end

	// register state
	pmc_byte_t power_mode_reg;
	pmc_byte_t clk_trans_reg;
	pmc_byte_t edge_sel_reg;
	pmc_byte_t rdata_next;

	// mode state
	pmc_mode_e mode_reg;
	pmc_mode_e mode_next;
	pmc_mode_e resume_reg;
	pmc_mode_e resume_next;
	logic direct_hit;
	logic wait_load;
	logic wait_done;
	logic [WAIT_W-1:0] wait_count;

	// clock generation
	logic watch_sync1_reg;
	logic watch_sync2_reg;
	logic watch_prev_reg;
	logic watch_tick;
	logic med_tick;
	logic sub_tick;
	logic noise_tick;
	logic [7:0] med_ratio;
	logic [7:0] sub_ratio;
	logic [7:0] noise_ratio;
	logic running;
	logic cpu_en_next;

	// field views
	logic software_standby;
	logic [2:0] standby_timer_select;
	logic low_speed_flag;
	logic [1:0] medium_clock_select;
	logic noise_sample_select;
	logic direct_transfer_flag;
	logic medium_speed_flag;
	logic [1:0] subactive_clock_select;
	logic int3_rising;

	assign software_standby = power_mode_reg[`PMC_PM_STBY_BIT];
	assign standby_timer_select =
		power_mode_reg[`PMC_PM_STS_HI:`PMC_PM_STS_LO];
	assign low_speed_flag = power_mode_reg[`PMC_PM_LOW_SPEED_BIT];
	assign medium_clock_select =
		power_mode_reg[`PMC_PM_MA_HI:`PMC_PM_MA_LO];
	assign noise_sample_select = clk_trans_reg[`PMC_CT_NOISE_BIT];
	assign direct_transfer_flag = clk_trans_reg[`PMC_CT_DIRECT_BIT];
	assign medium_speed_flag = clk_trans_reg[`PMC_CT_MED_BIT];
	assign subactive_clock_select =
		clk_trans_reg[`PMC_CT_SA_HI:`PMC_CT_SA_LO];
	assign int3_rising = edge_sel_reg[`PMC_ES_INT3_BIT];

	function automatic logic is_addr(input logic [7:0] a,
		input logic [7:0] ofs);
		is_addr = (a == ofs);
	endfunction

	// register writes; fixed bits keep their constant value
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST)
			power_mode_reg <= `PMC_PM_RESET;
		else if (REG_WR && is_addr(REG_ADDR, `PMC_OFS_POWER_MODE))
			power_mode_reg <= REG_WDATA | `PMC_PM_FIXED_MASK;
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST)
			clk_trans_reg <= `PMC_CT_RESET;
		else if (REG_WR && is_addr(REG_ADDR, `PMC_OFS_CLK_TRANS))
			clk_trans_reg <= REG_WDATA | `PMC_CT_FIXED_MASK;
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST)
			edge_sel_reg <= `PMC_ES_RESET;
		else if (REG_WR && is_addr(REG_ADDR, `PMC_OFS_EDGE_SEL))
			edge_sel_reg <= REG_WDATA & `PMC_ES_WRITE_MASK;
	end

	always_comb begin
		rdata_next = 8'h00;
		if (is_addr(REG_ADDR, `PMC_OFS_POWER_MODE)) begin
			rdata_next = power_mode_reg;
		end else if (is_addr(REG_ADDR, `PMC_OFS_CLK_TRANS)) begin
			rdata_next = clk_trans_reg;
		end else if (is_addr(REG_ADDR, `PMC_OFS_EDGE_SEL)) begin
			rdata_next = edge_sel_reg;
		end else if (is_addr(REG_ADDR, `PMC_OFS_MODE_STATUS)) begin
			rdata_next[`PMC_ST_MODE_HI:`PMC_ST_MODE_LO] = mode_reg;
			rdata_next[`PMC_ST_HOLD_BIT] = CPU_HOLD;
			rdata_next[`PMC_ST_OSC_BIT] = OSC_ENABLE;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST)
			REG_RDATA <= 8'h00;
		else if (REG_RD)
			REG_RDATA <= rdata_next;
		else
			REG_RDATA <= 8'h00;
	end

	// wait decode; the two long counts are parameters for simulation
	always_comb begin
		case (standby_timer_select) // see RULE1
		3'd0: wait_count = WAIT_W'(WAIT_CODE0_STATES);
		3'd1: wait_count = WAIT_W'(WAIT_CODE1_STATES);
		3'd2: wait_count = WAIT_W'(`PMC_WAIT_CODE2);
		3'd3: wait_count = WAIT_W'(`PMC_WAIT_CODE3);
		3'd4: wait_count = WAIT_W'(`PMC_WAIT_CODE4);
		3'd5: wait_count = WAIT_W'(`PMC_WAIT_CODE5);
		3'd6: wait_count = WAIT_W'(`PMC_WAIT_CODE6);
		default: wait_count = WAIT_W'(`PMC_WAIT_CODE7);
		endcase
	end

	// mode sequencing on a sleep instruction or a wakeup
	always_comb begin
		mode_next = mode_reg;
		resume_next = resume_reg;
		direct_hit = 1'b0;
		wait_load = 1'b0;
		case (mode_reg)
		PMC_ACT_HIGH, PMC_ACT_MED: begin
			if (SLEEP_EXEC) begin
				if (direct_transfer_flag) begin
					if (mode_reg == PMC_ACT_HIGH && !software_standby &&
						medium_speed_flag && !low_speed_flag) begin
						mode_next = PMC_ACT_MED; // see RULE10
						direct_hit = 1'b1;
					end else if (mode_reg == PMC_ACT_MED &&
						!software_standby && !medium_speed_flag &&
						!low_speed_flag) begin
						mode_next = PMC_ACT_HIGH; // see RULE11
						direct_hit = 1'b1;
					end else if (software_standby && TIMER_A_CLK_BIT &&
						low_speed_flag) begin
						mode_next = PMC_SUBACTIVE; // see RULE10 RULE11
						direct_hit = 1'b1;
					end
				end
				// no direct match falls back to a low-power entry
				if (!direct_hit) begin // see RULE9
					if (!software_standby) begin
						mode_next = PMC_SLEEP; // see RULE4
						resume_next = mode_reg;
					end else begin
						mode_next = TIMER_A_CLK_BIT ? PMC_WATCH :
							PMC_STANDBY; // see RULE5 RULE6
						resume_next = medium_speed_flag ? PMC_ACT_MED :
							PMC_ACT_HIGH;
					end
				end
			end
		end
		PMC_SUBACTIVE: begin
			if (SLEEP_EXEC) begin
				if (direct_transfer_flag && software_standby &&
					TIMER_A_CLK_BIT && !low_speed_flag) begin
					mode_next = medium_speed_flag ? PMC_ACT_MED :
						PMC_ACT_HIGH; // see RULE12
					direct_hit = 1'b1;
				end else if (!software_standby) begin
					mode_next = PMC_SUBSLEEP; // see RULE4 RULE9
					resume_next = PMC_SUBACTIVE;
				end else begin
					mode_next = PMC_WATCH; // see RULE5 RULE9
					resume_next = PMC_SUBACTIVE;
				end
			end
		end
		PMC_SLEEP, PMC_SUBSLEEP: begin
			if (WAKE_EVENT)
				mode_next = resume_reg;
		end
		PMC_STANDBY, PMC_WATCH: begin
			if (WAKE_EVENT) begin
				mode_next = PMC_OSC_WAIT; // see RULE15
				wait_load = 1'b1;
			end
		end
		PMC_OSC_WAIT: begin
			if (wait_done)
				mode_next = resume_reg; // see RULE15
		end
		default: begin
			mode_next = PMC_ACT_HIGH;
		end
		endcase
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_reg <= PMC_ACT_HIGH;
			resume_reg <= PMC_ACT_HIGH;
		end else begin
			mode_reg <= mode_next;
			resume_reg <= resume_next;
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST)
			DIRECT_TRANSITION <= 1'b0;
		else
			DIRECT_TRANSITION <= direct_hit;
	end

	pmc_wait_timer #(
		.WIDTH(WAIT_W)
	) u_wait (
		.clk(MCLK),
		.rst(SYS_RST),
		.load(wait_load),
		.count(wait_count),
		.busy(),
		.done(wait_done)
	);

	// watch subclock comes from a pin, so it is synchronised first
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			watch_sync1_reg <= 1'b0;
			watch_sync2_reg <= 1'b0;
			watch_prev_reg <= 1'b0;
		end else begin
			watch_sync1_reg <= WATCH_CLK_PIN;
			watch_sync2_reg <= watch_sync1_reg;
			watch_prev_reg <= watch_sync2_reg;
		end
	end

	assign watch_tick = watch_sync2_reg && !watch_prev_reg;

	always_comb begin
		case (medium_clock_select) // see RULE2
		2'd0: med_ratio = `PMC_MED_DIV0;
		2'd1: med_ratio = `PMC_MED_DIV1;
		2'd2: med_ratio = `PMC_MED_DIV2;
		default: med_ratio = `PMC_MED_DIV3;
		endcase
	end

	always_comb begin
		case (subactive_clock_select) // see RULE7
		2'd0: sub_ratio = `PMC_SUB_DIV0;
		2'd1: sub_ratio = `PMC_SUB_DIV1;
		default: sub_ratio = `PMC_SUB_DIV2;
		endcase
	end

	assign noise_ratio = noise_sample_select ? `PMC_NOISE_DIV1 :
		`PMC_NOISE_DIV0; // see RULE13

	pmc_divider #(
		.WIDTH(8)
	) u_med_div (
		.clk(MCLK),
		.rst(SYS_RST),
		.in_tick(OSC_ENABLE),
		.ratio(med_ratio),
		.out_tick(med_tick)
	);

	pmc_divider #(
		.WIDTH(8)
	) u_sub_div (
		.clk(MCLK),
		.rst(SYS_RST),
		.in_tick(watch_tick),
		.ratio(sub_ratio),
		.out_tick(sub_tick)
	);

	pmc_divider #(
		.WIDTH(8)
	) u_noise_div (
		.clk(MCLK),
		.rst(SYS_RST),
		.in_tick(OSC_ENABLE),
		.ratio(noise_ratio),
		.out_tick(noise_tick)
	);

	assign running = (mode_reg == PMC_ACT_HIGH) ||
		(mode_reg == PMC_ACT_MED) || (mode_reg == PMC_SUBACTIVE);

	// clock source follows the flag, speed follows the active state
	always_comb begin
		cpu_en_next = 1'b0;
		if (running) begin
			if (low_speed_flag)
				cpu_en_next = sub_tick; // see RULE3 RULE7
			else if (mode_reg == PMC_ACT_MED)
				cpu_en_next = med_tick; // see RULE8
			else
				cpu_en_next = 1'b1; // see RULE3 RULE8
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			CPU_CLK_EN <= 1'b0;
			CPU_CLK_FROM_SUB <= 1'b0;
			CPU_HOLD <= 1'b0;
			OSC_ENABLE <= 1'b1;
			NOISE_SAMPLE_EN <= 1'b0;
		end else begin
			CPU_CLK_EN <= cpu_en_next;
			CPU_CLK_FROM_SUB <= low_speed_flag; // see RULE3
			CPU_HOLD <= !(mode_next == PMC_ACT_HIGH ||
				mode_next == PMC_ACT_MED ||
				mode_next == PMC_SUBACTIVE); // see RULE15
			OSC_ENABLE <= !(mode_next == PMC_STANDBY ||
				mode_next == PMC_WATCH);
			NOISE_SAMPLE_EN <= noise_tick;
		end
	end

	assign POWER_MODE = mode_reg;

	// interrupt 3 and timer F share the one edge select bit
	logic [1:0] edge_pins;
	logic [1:0] edge_hits;
	assign edge_pins = {TIMER_F_PIN, EXT_INT3_PIN};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_edge
			logic sync1_reg;
			logic sync2_reg;
			logic prev_reg;
			logic hit_reg;
			always_ff @(posedge MCLK or posedge SYS_RST) begin
				// reset to the idle high level: no false edge after reset
				if (SYS_RST) begin
					sync1_reg <= 1'b1;
					sync2_reg <= 1'b1;
					prev_reg <= 1'b1;
					hit_reg <= 1'b0;
				end else begin
					sync1_reg <= edge_pins[gi];
					sync2_reg <= sync1_reg;
					prev_reg <= sync2_reg;
					hit_reg <= int3_rising ? (sync2_reg && !prev_reg) :
						(!sync2_reg && prev_reg); // see RULE14
				end
			end
			assign edge_hits[gi] = hit_reg;
		end
	endgenerate

	assign EXT_INT3_EDGE = edge_hits[0];
	assign TIMER_F_EDGE = edge_hits[1];
endmodule // pmc_power_mode_controller

// ---- verif/pmc_checker.sv ----
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_checker (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic SLEEP_EXEC,
	input wire logic TIMER_A_CLK_BIT,
	input wire logic [2:0] POWER_MODE,
	input wire logic CPU_HOLD,
	input wire logic OSC_ENABLE,
	input wire logic DIRECT_TRANSITION
);
	// shadows of the two control registers, taken from the bus itself
	logic [7:0] pm_reg;
	logic [7:0] ct_reg;
	logic go;
	logic dgo;
	logic ss;
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pm_reg <= `PMC_PM_RESET;
			ct_reg <= `PMC_CT_RESET;
		end else if (REG_WR && REG_ADDR == `PMC_OFS_POWER_MODE) begin
			pm_reg <= REG_WDATA;
		end else if (REG_WR && REG_ADDR == `PMC_OFS_CLK_TRANS) begin
			ct_reg <= REG_WDATA;
		end
	end
	assign go = SLEEP_EXEC && !ct_reg[3];
	assign dgo = SLEEP_EXEC && ct_reg[3];
	assign ss = pm_reg[7];
	default clocking @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	AST_RD_IDLE: assert property (!REG_RD |=> REG_RDATA == 8'h00)
		else $error("read data not zero outside read slot");
	AST_SLEEP_ACT: assert property (
		go && !ss && POWER_MODE <= 3'd1 |=> POWER_MODE == 3'd3)
		else $error("active sleep entry wrong");
	AST_SLEEP_SUB: assert property (
		go && !ss && POWER_MODE == 3'd2 |=> POWER_MODE == 3'd4)
		else $error("subsleep entry wrong");
	AST_STBY_ACT: assert property (
		go && ss && POWER_MODE <= 3'd1 && !TIMER_A_CLK_BIT |=>
		POWER_MODE == 3'd5)
		else $error("standby entry wrong");
	AST_WATCH_ACT: assert property (
		go && ss && POWER_MODE <= 3'd1 && TIMER_A_CLK_BIT |=>
		POWER_MODE == 3'd6)
		else $error("watch entry wrong");
	AST_WATCH_SUB: assert property (
		go && ss && POWER_MODE == 3'd2 |=> POWER_MODE == 3'd6)
		else $error("watch from subactive wrong");
	AST_DIRECT_MED: assert property (
		dgo && POWER_MODE == 3'd0 && !ss &&
		ct_reg[2] && !pm_reg[3] |=>
		POWER_MODE == 3'd1 && DIRECT_TRANSITION)
		else $error("direct high to medium wrong");
	AST_DIRECT_SUB: assert property (
		dgo && POWER_MODE == 3'd2 && ss &&
		TIMER_A_CLK_BIT && !pm_reg[3] |=>
		POWER_MODE == {2'b00, $past(ct_reg[2])})
		else $error("direct subactive to active wrong");
	AST_WAIT_SHORT: assert property (
		POWER_MODE == 3'd7 && $past(POWER_MODE) != 3'd7 &&
		pm_reg[6:4] == 3'd5 |->
		POWER_MODE == 3'd7 [*3] ##1 POWER_MODE != 3'd7)
		else $error("two-state wait length wrong");
	AST_HOLD: assert property (
		CPU_HOLD == (POWER_MODE >= 3'd3) &&
		OSC_ENABLE == !(POWER_MODE inside {3'd5, 3'd6}))
		else $error("hold or oscillator enable disagrees with mode");
endmodule // pmc_checker
bind pmc_power_mode_controller pmc_checker i_chk (.MCLK, .SYS_RST, .REG_ADDR,
	.REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .SLEEP_EXEC, .TIMER_A_CLK_BIT,
	.POWER_MODE, .CPU_HOLD, .OSC_ENABLE, .DIRECT_TRANSITION);

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
	logic MCLK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0;
	logic SLEEP_EXEC = 0, WAKE_EVENT = 0, TIMER_A_CLK_BIT = 0;
	logic WATCH_CLK_PIN = 0, EXT_INT3_PIN = 1, TIMER_F_PIN = 1;
	logic [7:0] REG_ADDR = 0, REG_WDATA = 0, REG_RDATA;
	logic [2:0] POWER_MODE;
	logic CPU_CLK_EN, CPU_CLK_FROM_SUB, CPU_HOLD, OSC_ENABLE;
	logic NOISE_SAMPLE_EN, DIRECT_TRANSITION, EXT_INT3_EDGE, TIMER_F_EDGE;
	int miscompares = 0, cmp_count = 0, i;
	int w[8] = '{20, 40, 1024, 2048, 4096, 2, 8, 16};
	logic [7:0] a, d;
	// short wait codes so the run stays small
	pmc_power_mode_controller #(.WAIT_CODE0_STATES(20),
		.WAIT_CODE1_STATES(40)) i_dut (.MCLK, .SYS_RST, .REG_ADDR,
		.REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .SLEEP_EXEC, .WAKE_EVENT,
		.TIMER_A_CLK_BIT, .WATCH_CLK_PIN, .EXT_INT3_PIN, .TIMER_F_PIN,
		.POWER_MODE, .CPU_CLK_EN, .CPU_CLK_FROM_SUB, .CPU_HOLD, .OSC_ENABLE,
		.NOISE_SAMPLE_EN, .DIRECT_TRANSITION, .EXT_INT3_EDGE,
		.TIMER_F_EDGE);
	initial forever #2.5 MCLK = ~MCLK;
	// watch clock is 8 MCLK periods, phase offset from MCLK
	initial begin
		#1.3;
		forever #20 WATCH_CLK_PIN = ~WATCH_CLK_PIN;
	end
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(int n = 1);
		repeat (n) @(posedge MCLK);
	endtask
	task automatic wr(logic [7:0] ad, logic [7:0] dt);
		REG_ADDR <= ad;
		REG_WDATA <= dt;
		REG_WR <= 1'b1;
		tick();
		REG_WR <= 1'b0;
		tick();
	endtask
	task automatic rd(logic [7:0] ad, logic [7:0] e);
		REG_ADDR <= ad;
		REG_RD <= 1'b1;
		tick();
		REG_RD <= 1'b0;
		#1 chk(REG_RDATA, e);
		tick();
	endtask
	// w1: wake event, else sleep instruction
	task automatic pulse(logic w1, logic [2:0] e);
		if (w1) WAKE_EVENT <= 1'b1;
		else SLEEP_EXEC <= 1'b1;
		tick();
		WAKE_EVENT <= 1'b0;
		SLEEP_EXEC <= 1'b0;
		#1 chk(POWER_MODE, e);
		chk(CPU_HOLD, 16'(e >= 3'd3));
		tick();
	endtask
	task automatic owait(int n, logic [2:0] e);
		int c;
		c = 1;
		#1;
		while (POWER_MODE === 3'd7 && c < 20000) begin
			c++;
			tick();
			#1;
		end
		chk(16'(c), 16'(n + 1));
		chk(POWER_MODE, e);
		tick();
	endtask
	// spacing of pulses on the cpu enable (0) or noise sampler (1)
	task automatic per(int sel, int e);
		int c;
		for (int k = 0; k < 3; k++) begin
			c = 0;
			do begin
				tick();
				#1;
				c++;
			end while (!(sel ? NOISE_SAMPLE_EN : CPU_CLK_EN) && c < 300);
		end
		chk(16'(c), 16'(e));
		tick();
	endtask
	task automatic edg(logic sel, logic lvl);
		int ia, ib;
		ia = 0;
		ib = 0;
		EXT_INT3_PIN <= lvl;
		TIMER_F_PIN <= lvl;
		repeat (8) begin
			tick();
			#1;
			ia += EXT_INT3_EDGE;
			ib += TIMER_F_EDGE;
		end
		chk(16'(ia), 16'(sel == lvl));
		chk(16'(ib), 16'(sel == lvl));
		tick();
	endtask
	function automatic logic [7:0] fix(logic [7:0] ad, logic [7:0] dt);
		if (ad == 8'h00) return dt | 8'h04;
		if (ad == 8'h01) return dt | 8'he0;
		return dt & 8'h01;
	endfunction
	task automatic done(string s);
		$display("test done: %s", s);
	endtask
	task automatic results();
		$display("compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#400000;
		miscompares++;
		results();
	end
	initial begin
		void'($urandom(32'h5003f370));
		tick(10);
		SYS_RST <= 1'b0;
		tick();
		rd(8'h00, 8'h07);
		rd(8'h01, 8'hf0);
		rd(8'h7f, 8'h00);
		for (i = 0; i < 12; i++) begin
			a = 8'($urandom_range(2));
			d = 8'($urandom);
			wr(a, d);
			rd(a, fix(a, d));
		end
		done("registers");
		wr(8'h01, 8'h00);
		for (i = 0; i < 8; i++) begin
			wr(8'h00, 8'h80 | 8'(i << 4));
			TIMER_A_CLK_BIT <= 1'b0;
			pulse(1'b0, 3'd5);
			pulse(1'b1, 3'd7);
			owait(w[i], 3'd0);
		end
		TIMER_A_CLK_BIT <= 1'b1;
		pulse(1'b0, 3'd6);
		pulse(1'b1, 3'd7);
		owait(w[7], 3'd0);
		wr(8'h00, 8'h00);
		pulse(1'b0, 3'd3);
		rd(8'h03, 8'h1b);
		pulse(1'b1, 3'd0);
		done("standby wait and sleep");
		wr(8'h01, 8'h0c);
		pulse(1'b0, 3'd1);
		for (i = 0; i < 4; i++) begin
			wr(8'h00, 8'(i));
			per(0, 16 << i);
		end
		wr(8'h01, 8'h1c);
		per(1, 4);
		wr(8'h01, 8'h0c);
		per(1, 16);
		wr(8'h01, 8'h08);
		pulse(1'b0, 3'd0);
		per(0, 1);
		done("direct and medium clocks");
		wr(8'h00, 8'hd8);
		pulse(1'b0, 3'd2);
		for (i = 0; i < 4; i++) begin
			wr(8'h01, 8'h08 | 8'(i));
			per(0, 8 * (i > 1 ? 2 : 8 >> i));
			chk(CPU_CLK_FROM_SUB, 1'b1);
		end
		wr(8'h01, 8'h00);
		pulse(1'b0, 3'd6);
		pulse(1'b1, 3'd7);
		owait(2, 3'd2);
		wr(8'h00, 8'h08);
		pulse(1'b0, 3'd4);
		pulse(1'b1, 3'd2);
		done("subactive");
		wr(8'h01, 8'h08);
		wr(8'h00, 8'h80);
		pulse(1'b0, 3'd0);
		tick(3);
		chk(CPU_CLK_FROM_SUB, 1'b0);
		wr(8'h00, 8'h88);
		pulse(1'b0, 3'd2);
		wr(8'h01, 8'h0c);
		wr(8'h00, 8'h80);
		pulse(1'b0, 3'd1);
		wr(8'h01, 8'h04);
		wr(8'h00, 8'h00);
		pulse(1'b0, 3'd3);
		pulse(1'b1, 3'd1);
		done("direct from subactive");
		for (i = 0; i < 2; i++) begin
			wr(8'h02, 8'(i));
			edg(i[0], 1'b0);
			edg(i[0], 1'b1);
		end
		done("edges");
		SYS_RST <= 1'b1;
		tick(2);
		SYS_RST <= 1'b0;
		tick();
		rd(8'h01, 8'hf0);
		chk(POWER_MODE, 3'd0);
		rd(8'h03, 8'h10);
		done("second reset");
		results();
	end
endmodule // tb
